// >>> inc/isb_pkg.sv
// Package: constants and types for the inc/dec/skip/branch execute block
// Operation
// [RULE_01] Decrement-skip writes file minus one to the accumulator when the destination bit is 0, else to the file.
// [RULE_02] Decrement-skip with a zero result squashes the next instruction into a no-operation; otherwise no flag changes.
// [RULE_03] Both increments write file plus one to the accumulator when the destination bit is 0, else to the file.
// [RULE_04] Increment-skip with a zero result squashes the next instruction; otherwise no flag changes.
// [RULE_05] The jump loads its 11-bit immediate into program counter bits 10 to 0.
// [RULE_06] The jump fills program counter bits 12 and 11 from bits 4 and 3 of the high latch.
// [RULE_07] The jump always transfers control, takes two cycles and leaves flags unchanged.
// [RULE_08] Literal OR ORs the accumulator with the 8-bit literal and writes the accumulator.
// [RULE_09] Plain increment and literal OR set the zero flag on a zero result and clear it otherwise.
package isb_pkg;
    // ------------------------------------------------------------
    // Instruction encoding
    // ------------------------------------------------------------
    localparam int          INSN_W      = 14;
    localparam int          PC_W        = 13;
    localparam int          FADDR_W     = 7;
    localparam int          DATA_W      = 8;
    localparam int          DEST_BIT    = 7;
    localparam int          JUMP_LSB    = 0;
    localparam int          JUMP_W      = 11;
    localparam int          LATCH_PAGE_LO = 3;
    localparam logic [5:0]  OP_DEC_SKIP = 6'h0b;
    localparam logic [5:0]  OP_INC_SKIP = 6'h0f;
    localparam logic [5:0]  OP_INC_FILE = 6'h0a;
    localparam logic [4:0]  OP_OR_LIT   = 5'h1c; // 11 1000 kkkk kkkk, bits 13:9
    localparam logic [2:0]  OP_JUMP     = 3'h5;  // 10 1kkk kkkk kkkk
    localparam logic [13:0] INSN_NOP    = 14'h0000;
    localparam logic [7:0]  ACC_RESET   = 8'h00;

    typedef enum logic [2:0] {
        ST_EXEC   = 3'b001,
        ST_SQUASH = 3'b010,
        ST_IDLE   = 3'b100
    } isb_state_t;

    typedef struct packed {
        logic              wr_acc;
        logic              wr_file;
        logic [6:0]        file_addr;
        logic [7:0]        data;
    } isb_wb_t;

    typedef struct packed {
        isb_state_t        state;
        logic [7:0]        acc;
        logic              zero;
        logic              pc_load;
        logic [12:0]       pc_target;
        logic              squash;
        isb_wb_t           wb;
    } isb_regs_t;
endpackage : isb_pkg

// >>> hdl/isb_exec.sv
// Execute stage for decrement/increment-skip, increment, literal OR and jump
`timescale 1ns/1ps
`default_nettype none
module isb_exec (
    input  wire logic                ref_clk,      // Core instruction clock, 10 MHz
    input  wire logic                reset,        // Synchronous, active high
    input  wire logic                insn_valid,   // Instruction present this cycle
    input  wire logic [13:0]         insn,         // Fetched instruction word
    input  wire logic [7:0]          file_rdata,   // Addressed file register contents
    input  wire logic [7:0]          pc_high_latch,// Program counter high latch
    output logic      [6:0]          file_raddr,   // File address being read
    output isb_pkg::isb_wb_t         wb,           // Registered write-back
    output logic      [7:0]          acc,          // Accumulator (working register)
    output logic                     zero_flag,    // Zero flag
    output logic                     pc_load,      // Pulse: load program counter
    output logic      [12:0]         pc_target,    // New program counter value
    output logic                     squash        // High while a no-operation runs
);
    isb_pkg::isb_regs_t r_reg, r_next;
    logic [7:0] inc_v, dec_v, or_v;
    logic       dest_file, skip_cycle;

    // ------------------------------------------------------------
    // Operand decode
    // ------------------------------------------------------------
    assign dest_file  = insn[isb_pkg::DEST_BIT];
    assign inc_v      = file_rdata + 8'h01;
    assign dec_v      = file_rdata - 8'h01;
    assign or_v       = r_reg.acc | insn[7:0];
    assign skip_cycle = (r_reg.state == isb_pkg::ST_SQUASH);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next              = r_reg;
        r_next.pc_load      = 1'b0;
        r_next.squash       = 1'b0;
        r_next.wb.wr_acc    = 1'b0;
        r_next.wb.wr_file   = 1'b0;
        r_next.wb.file_addr = insn[6:0];
        r_next.state        = isb_pkg::ST_EXEC;
        case (r_reg.state)
            isb_pkg::ST_SQUASH: begin
                // Fetched word is thrown away; no-operation in its place
                r_next.squash = 1'b1;                                  // [RULE_02] [RULE_04] [RULE_07]
            end
            isb_pkg::ST_EXEC, isb_pkg::ST_IDLE: begin
                if (insn_valid) begin
                    if (insn[13:8] == isb_pkg::OP_DEC_SKIP) begin
                        r_next.wb.data    = dec_v;                     // [RULE_01]
                        r_next.wb.wr_acc  = ~dest_file;
                        r_next.wb.wr_file = dest_file;
                        if (!dest_file) r_next.acc = dec_v;
                        if (dec_v == 8'h00) r_next.state = isb_pkg::ST_SQUASH; // [RULE_02]
                    end else if (insn[13:8] == isb_pkg::OP_INC_SKIP ||
                                 insn[13:8] == isb_pkg::OP_INC_FILE) begin
                        r_next.wb.data    = inc_v;                     // [RULE_03]
                        r_next.wb.wr_acc  = ~dest_file;
                        r_next.wb.wr_file = dest_file;
                        if (!dest_file) r_next.acc = inc_v;
                        if (insn[13:8] == isb_pkg::OP_INC_FILE) begin
                            r_next.zero = (inc_v == 8'h00);            // [RULE_09]
                        end else if (inc_v == 8'h00) begin
                            r_next.state = isb_pkg::ST_SQUASH;         // [RULE_04]
                        end
                    end else if (insn[13:9] == isb_pkg::OP_OR_LIT) begin
                        r_next.acc       = or_v;                       // [RULE_08]
                        r_next.wb.data   = or_v;
                        r_next.wb.wr_acc = 1'b1;
                        r_next.zero      = (or_v == 8'h00);            // [RULE_09]
                    end else if (insn[13:11] == isb_pkg::OP_JUMP) begin
                        r_next.pc_load = 1'b1;                         // [RULE_07]
                        r_next.pc_target = {pc_high_latch[isb_pkg::LATCH_PAGE_LO +: 2], // [RULE_06]
                                            insn[isb_pkg::JUMP_LSB +: isb_pkg::JUMP_W]}; // [RULE_05]
                        r_next.state = isb_pkg::ST_SQUASH;             // [RULE_07]
                    end
                end
            end
            default: r_next.state = isb_pkg::ST_EXEC;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r_reg.state     <= isb_pkg::ST_IDLE;
            r_reg.acc       <= isb_pkg::ACC_RESET;
            r_reg.zero      <= 1'b0;
            r_reg.pc_load   <= 1'b0;
            r_reg.pc_target <= 13'h0000;
            r_reg.squash    <= 1'b0;
            r_reg.wb        <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Read address stays combinational so file_rdata returns in the same cycle
    assign file_raddr = insn[6:0];
    assign wb         = r_reg.wb;
    assign acc        = r_reg.acc;
    assign zero_flag  = r_reg.zero;
    assign pc_load    = r_reg.pc_load;
    assign pc_target  = r_reg.pc_target;
    assign squash     = r_reg.squash;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Reset is synchronous; checks pause while it is held
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_dec_dest;
        (r_reg.state != isb_pkg::ST_SQUASH && insn_valid && insn[13:8] == isb_pkg::OP_DEC_SKIP)
            |=> wb.data == $past(file_rdata) - 8'h01 && wb.wr_file == $past(insn[7]) && wb.wr_acc == !$past(insn[7]);
    endproperty
    a_dec_dest: assert property (p_dec_dest) else $error("decrement result or destination wrong"); // [RULE_01]
    property p_dec_skip;
        (!skip_cycle && insn_valid && insn[13:8] == isb_pkg::OP_DEC_SKIP && file_rdata == 8'h01 && !reset)
            |=> ##1 squash;
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("decrement zero did not squash"); // [RULE_02]

    property p_dec_acc;
        (!skip_cycle && insn_valid && insn[13:8] == isb_pkg::OP_DEC_SKIP)
            |=> acc == ($past(insn[isb_pkg::DEST_BIT]) ? $past(acc) : $past(file_rdata) - 8'h01);
    endproperty
    a_dec_acc: assert property (p_dec_acc) else $error("decrement accumulator wrong"); // [RULE_01]
    property p_dec_run;
        (!skip_cycle && insn_valid && insn[13:8] == isb_pkg::OP_DEC_SKIP && file_rdata != 8'h01)
            |=> ##1 !squash;
    endproperty
    a_dec_run: assert property (p_dec_run) else $error("decrement nonzero squashed"); // [RULE_02]
    property p_inc_dest;
        (!skip_cycle && insn_valid && (insn[13:8] == isb_pkg::OP_INC_FILE || insn[13:8] == isb_pkg::OP_INC_SKIP))
            |=> wb.data == $past(file_rdata) + 8'h01 && wb.wr_file == $past(insn[7]);
    endproperty
    a_inc_dest: assert property (p_inc_dest) else $error("increment result or destination wrong"); // [RULE_03]
    property p_inc_skip;
        (!skip_cycle && insn_valid && insn[13:8] == isb_pkg::OP_INC_SKIP)
            |=> ##1 (squash == ($past(file_rdata, 2) == 8'hff));
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("increment skip mismatch"); // [RULE_04]

    property p_inc_acc;
        (!skip_cycle && insn_valid && (insn[13:8] == isb_pkg::OP_INC_FILE || insn[13:8] == isb_pkg::OP_INC_SKIP))
            |=> acc == ($past(insn[isb_pkg::DEST_BIT]) ? $past(acc) : $past(file_rdata) + 8'h01);
    endproperty
    a_inc_acc: assert property (p_inc_acc) else $error("increment accumulator wrong"); // [RULE_03]
    property p_inc_file_zero;
        (!skip_cycle && insn_valid && insn[13:8] == isb_pkg::OP_INC_FILE)
            |=> zero_flag == ($past(file_rdata) == 8'hff);
    endproperty
    a_inc_file_zero: assert property (p_inc_file_zero) else $error("increment zero flag wrong"); // [RULE_09]
    property p_inc_file_run;
        (!skip_cycle && insn_valid && insn[13:8] == isb_pkg::OP_INC_FILE)
            |=> ##1 !squash;
    endproperty
    a_inc_file_run: assert property (p_inc_file_run) else $error("plain increment squashed"); // [RULE_03]
    property p_jump_low;
        (!skip_cycle && insn_valid && insn[13:11] == isb_pkg::OP_JUMP)
            |=> pc_load && pc_target[10:0] == $past(insn[10:0]);
    endproperty
    a_jump_low: assert property (p_jump_low) else $error("jump low bits wrong"); // [RULE_05]
    property p_jump_high;
        (!skip_cycle && insn_valid && insn[13:11] == isb_pkg::OP_JUMP)
            |=> pc_target[12:11] == $past(pc_high_latch[4:3]);
    endproperty
    a_jump_high: assert property (p_jump_high) else $error("jump page bits wrong"); // [RULE_06]

    property p_jump_quiet;
        (!skip_cycle && insn_valid && insn[13:11] == isb_pkg::OP_JUMP)
            |=> !wb.wr_acc && !wb.wr_file && $stable(acc) && $stable(zero_flag);
    endproperty
    a_jump_quiet: assert property (p_jump_quiet) else $error("jump wrote data or flags"); // [RULE_07]
    property p_jump_two;
        pc_load |-> (!squash && $stable(zero_flag)) ##1 (squash && $stable(zero_flag));
    endproperty
    a_jump_two: assert property (p_jump_two) else $error("jump not two cycles"); // [RULE_07]
    property p_or_lit;
        (!skip_cycle && insn_valid && insn[13:9] == isb_pkg::OP_OR_LIT)
            |=> acc == ($past(acc) | $past(insn[7:0])) && zero_flag == (acc == 8'h00);
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("literal OR wrong"); // [RULE_08] [RULE_09]
    property p_or_dest;
        (!skip_cycle && insn_valid && insn[13:9] == isb_pkg::OP_OR_LIT)
            |=> wb.wr_acc && !wb.wr_file && wb.data == acc;
    endproperty
    a_or_dest: assert property (p_or_dest) else $error("literal OR write-back wrong"); // [RULE_08]
    property p_skip_zero;
        (!skip_cycle && insn_valid && (insn[13:8] == isb_pkg::OP_DEC_SKIP || insn[13:8] == isb_pkg::OP_INC_SKIP))
            |=> $stable(zero_flag);
    endproperty
    a_skip_zero: assert property (p_skip_zero) else $error("skip changed zero flag"); // [RULE_09]

    // ------------------------------------------------------------
    // No-operation slot
    // ------------------------------------------------------------
    property p_pc_load_pulse;
        pc_load |=> !pc_load;
    endproperty
    a_pc_load_pulse: assert property (p_pc_load_pulse) else $error("jump load too long"); // [RULE_07]
    property p_squash_pulse;
        squash |=> !squash;
    endproperty
    a_squash_pulse: assert property (p_squash_pulse) else $error("no-operation too long"); // [RULE_02] [RULE_04]
    property p_squash_quiet;
        skip_cycle |=> squash && !pc_load && !wb.wr_acc && !wb.wr_file && $stable(acc) && $stable(zero_flag);
    endproperty
    a_squash_quiet: assert property (p_squash_quiet) else $error("discarded word had an effect"); // [RULE_07]

    c_jump:    cover property (pc_load);
    c_squash:  cover property (squash);
    c_or_zero: cover property (zero_flag && wb.wr_acc);
    c_dec_zero: cover property (!skip_cycle && insn_valid && insn[13:8] == isb_pkg::OP_DEC_SKIP && file_rdata == 8'h01);
    c_inc_zero: cover property (!skip_cycle && insn_valid && insn[13:8] == isb_pkg::OP_INC_SKIP && file_rdata == 8'hff);
endmodule // isb_exec
`default_nettype wire

// >>> tb/isb_exec_tb.sv
// Self-checking bench for the inc/dec/skip/jump execute block
`timescale 1ns/1ps
`default_nettype none
module isb_exec_tb;
    logic             ref_clk, reset, insn_valid, zero_flag, pc_load, squash, skip;
    logic [13:0]      insn;
    logic [7:0]       file_rdata, pc_high_latch, acc;
    logic [6:0]       file_raddr;
    logic [12:0]      pc_target;
    isb_pkg::isb_wb_t wb;
    int               n_errors, comparisons, m_acc, m_zero, m_pc, kind, fv, k, r, d, lt;
    int               acc_q[$];

    isb_exec isb_exec_inst (.ref_clk(ref_clk), .reset(reset), .insn_valid(insn_valid), .insn(insn),
        .file_rdata(file_rdata), .pc_high_latch(pc_high_latch), .file_raddr(file_raddr), .wb(wb),
        .acc(acc), .zero_flag(zero_flag), .pc_load(pc_load), .pc_target(pc_target), .squash(squash));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog: about four cycles per instruction, ample margin
    // ------------------------------------------------------------
    initial begin
        #1ms;
        n_errors++;
        stop_test();
    end

    initial begin
        n_errors = 0; comparisons = 0; m_acc = 0; m_zero = 0; m_pc = 0;
        reset = 1'b1; insn_valid = 1'b0; insn = 14'h0000; file_rdata = 8'h00; pc_high_latch = 8'h00;
        void'($urandom(32'h5a91));
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        check("acc", 0, acc);
        check("pc_target", 0, pc_target);
        check("pulses", 0, {pc_load, squash, zero_flag, wb.wr_acc, wb.wr_file});
        for (int i = 0; i < 250; i++) begin
            // Mid-run reset must clear accumulator, flag and target again
            if (i == 125) begin
                @(posedge ref_clk);
                reset <= 1'b1;
                repeat (2) @(posedge ref_clk);
                reset <= 1'b0;
                #1;
                check("acc", 0, acc);
                check("pc_target", 0, pc_target);
                check("pulses", 0, {pc_load, squash, zero_flag, wb.wr_acc, wb.wr_file});
                m_acc = 0;
                m_zero = 0;
                m_pc = 0;
            end
            kind = i % 5;
            // Boundary file values 0, 1, ff half the time
            fv = ($urandom % 2) ? $urandom % 256 : (($urandom % 3) + 255) % 256;
            k = ($urandom % 4) ? $urandom : 0;
            d = $urandom % 2;
            lt = $urandom % 256;
            @(posedge ref_clk);
            pc_high_latch <= lt[7:0];
            file_rdata <= fv[7:0];
            insn_valid <= 1'b1;
            case (kind)
                0: insn <= {isb_pkg::OP_DEC_SKIP, d[0], k[6:0]};
                1: insn <= {isb_pkg::OP_INC_SKIP, d[0], k[6:0]};
                2: insn <= {isb_pkg::OP_INC_FILE, d[0], k[6:0]};
                3: insn <= {isb_pkg::OP_OR_LIT, 1'b0, k[7:0]};
                default: insn <= {isb_pkg::OP_JUMP, k[10:0]};
            endcase
            r = 0;
            skip = 1'b0;
            case (kind)
                0: begin r = (fv + 255) % 256; skip = (r == 0); end
                1: begin r = (fv + 1) % 256; skip = (r == 0); end
                2: begin r = (fv + 1) % 256; m_zero = (r == 0); end
                3: begin m_acc = m_acc | (k & 255); m_zero = (m_acc == 0); end
                default: begin m_pc = {lt[4:3], k[10:0]}; skip = 1'b1; end
            endcase
            if (kind < 3 && d == 0) m_acc = r;
            acc_q.push_back(m_acc);
            #1;
            if (kind < 3) check("file_raddr", k[6:0], file_raddr);
            @(posedge ref_clk);
            // Junk word offered in the slot a skip or jump must discard
            insn_valid <= skip;
            insn <= 14'($urandom);
            file_rdata <= 8'($urandom);
            #1;
            check("acc", acc_q.pop_front(), acc);
            check("zero_flag", m_zero, zero_flag);
            check("pc_load", kind == 4, pc_load);
            check("pc_target", m_pc, pc_target);
            check("wb.wr_acc", (kind < 3 && d == 0) || kind == 3, wb.wr_acc);
            check("wb.wr_file", kind < 3 && d == 1, wb.wr_file);
            if (kind < 4) check("wb.data", (kind == 3) ? m_acc : r, wb.data);
            if (kind < 3) check("wb.file_addr", k[6:0], wb.file_addr);
            @(posedge ref_clk);
            insn_valid <= 1'b0;
            #1;
            check("squash", skip, squash);
            @(posedge ref_clk);
            #1;
            check("acc", m_acc, acc);
            check("pulses", 0, {pc_load, squash, wb.wr_acc, wb.wr_file});
        end
        stop_test();
    end
endmodule // isb_exec_tb
`default_nettype wire
